// ---- dio_counter_top.sv ----
`timescale 1ns/10ps
// Functional notes
// (R1) Two sixteen-line ports, each line bidirectional
// (R2) Reset: port A inputs, port B outputs
// (R3) Digital inputs captured on analog sample strobe
// (R4) Outside must not drive device outputs
// (R5) Host sets direction before using port
// (R6) Three independent 32-bit encoder-capable counters
// (R7) Counter A, B, reset selectable from any line
// (R8) Counters count only with lines assigned
// (R9) Plain mode counts rising edges on A
// (R10) Passing maximum wraps to minimum value
// (R11) Assigned external reset clears counter anytime
// (R12) Quadrature direction from A/B phase relation
// (R13) Encoder mode: two lines, signed 32-bit range
// (R14) Push-buttons must be debounced outside
// (R15) Direction chosen per group of eight lines
// (R16) Value readable live, two's complement up/down
// (R17) Inputs synchronised before edge detection
module dio_counter_top
  import dio_counter_pkg::*;
(
  input  wire logic                                     CLK_I,
  input  wire logic                                     SYS_RST_I,
  // Port pads: in, out, active low enable
  input  wire logic [dio_counter_pkg::PORT_W-1:0]       PORTA_IN_I,
  output logic      [dio_counter_pkg::PORT_W-1:0]       PORTA_OUT_O,
  output logic      [dio_counter_pkg::PORT_W-1:0]       PORTA_OE_N_O,
  input  wire logic [dio_counter_pkg::PORT_W-1:0]       PORTB_IN_I,
  output logic      [dio_counter_pkg::PORT_W-1:0]       PORTB_OUT_O,
  output logic      [dio_counter_pkg::PORT_W-1:0]       PORTB_OE_N_O,
  // Direction control, one bit per group of eight, 1 is output
  input  wire logic                                     DIR_WE_I,
  input  wire logic [dio_counter_pkg::NUM_GROUPS-1:0]   DIR_I,
  output logic      [dio_counter_pkg::NUM_GROUPS-1:0]   DIR_O,
  // Output data write
  input  wire logic                                     OUT_WE_I,
  input  wire logic [dio_counter_pkg::PORT_W-1:0]       OUT_A_I,
  input  wire logic [dio_counter_pkg::PORT_W-1:0]       OUT_B_I,
  // Sample strobe shared with the analog inputs
  input  wire logic                                     SAMPLE_I,
  output logic      [dio_counter_pkg::NUM_LINES-1:0]    DIN_O,
  output logic                                          SAMPLE_VALID_O,
  // Counter configuration, packed per counter
  input  wire logic [dio_counter_pkg::NUM_CNT-1:0]      CNT_ASSIGN_I,
  input  wire logic [dio_counter_pkg::NUM_CNT*3-1:0]    CNT_MODE_I,
  input  wire logic [dio_counter_pkg::NUM_CNT*5-1:0]    CNT_SEL_A_I,
  input  wire logic [dio_counter_pkg::NUM_CNT*5-1:0]    CNT_SEL_B_I,
  input  wire logic [dio_counter_pkg::NUM_CNT*5-1:0]    CNT_SEL_RST_I,
  input  wire logic [dio_counter_pkg::NUM_CNT-1:0]      CNT_RST_EN_I,
  // Counter values, counter 0 in the low word
  output logic      [dio_counter_pkg::NUM_CNT*32-1:0]   CNT_VALUE_O
);

  logic [NUM_LINES-1:0]  pads;
  logic [NUM_LINES-1:0]  lines;
  logic [NUM_CNT-1:0]    cnt_a;
  logic [NUM_CNT-1:0]    cnt_b;
  logic [NUM_CNT-1:0]    cnt_r;

  // Line picker shared by all counter inputs
  function automatic logic pick_line(input logic [NUM_LINES-1:0] src,
                                     input logic [SEL_W-1:0]     sel);
    return src[sel]; // (R7)
  endfunction : pick_line

  // Line 0..15 is port A, 16..31 is port B
  assign pads = {PORTB_IN_I, PORTA_IN_I};

  line_sync u_sync (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .lines_i (pads),
    .lines_o (lines)
  );

  // Direction register per group of eight
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      DIR_O <= DIR_RESET; // (R2)
    end else if (DIR_WE_I) begin
      DIR_O <= DIR_I; // (R15)
    end
  end

  // Pad enables follow the written direction, low drives
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      PORTA_OE_N_O <= OE_N_IN;  // (R2)
      PORTB_OE_N_O <= OE_N_OUT; // (R2)
    end else if (DIR_WE_I) begin
      PORTA_OE_N_O <= {{GROUP_W{~DIR_I[1]}}, {GROUP_W{~DIR_I[0]}}}; // (R15) (R1)
      PORTB_OE_N_O <= {{GROUP_W{~DIR_I[3]}}, {GROUP_W{~DIR_I[2]}}}; // (R15) (R1)
    end
  end

  // Output data registers
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      PORTA_OUT_O <= DOUT_RESET;
      PORTB_OUT_O <= DOUT_RESET;
    end else if (OUT_WE_I) begin
      PORTA_OUT_O <= OUT_A_I; // (R1)
      PORTB_OUT_O <= OUT_B_I; // (R1)
    end
  end

  // Input snapshot at the analog sampling instant
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      DIN_O          <= DIN_RESET;
      SAMPLE_VALID_O <= 1'b0;
    end else begin
      SAMPLE_VALID_O <= SAMPLE_I; // (R3)
      if (SAMPLE_I) begin
        DIN_O <= lines; // (R3)
      end
    end
  end

  // Three counters with routed inputs
  generate
    for (genvar c = 0; c < NUM_CNT; c++) begin : g_cnt
      assign cnt_a[c] = pick_line(lines, CNT_SEL_A_I[c*SEL_W +: SEL_W]);   // (R7)
      assign cnt_b[c] = pick_line(lines, CNT_SEL_B_I[c*SEL_W +: SEL_W]);   // (R7)
      assign cnt_r[c] = pick_line(lines, CNT_SEL_RST_I[c*SEL_W +: SEL_W]); // (R7)

      quad_counter u_cnt (
        .clk_i        (CLK_I),
        .rst_i        (SYS_RST_I),
        .assign_i     (CNT_ASSIGN_I[c]),
        .mode_i       (CNT_MODE_I[c*MODE_W +: MODE_W]),
        .a_i          (cnt_a[c]),
        .b_i          (cnt_b[c]),
        .ext_rst_en_i (CNT_RST_EN_I[c]),
        .ext_rst_i    (cnt_r[c]),
        .value_o      (CNT_VALUE_O[c*CNT_W +: CNT_W])
      );

      a_unassigned_hold : assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // (R8)
        !CNT_ASSIGN_I[c] |=> $stable(CNT_VALUE_O[c*CNT_W +: CNT_W]))
        else $error("unassigned counter changed value");
    end
  endgenerate

  a_reset_dir : assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // (R2)
    $fell(SYS_RST_I) |-> PORTA_OE_N_O == OE_N_IN && PORTB_OE_N_O == OE_N_OUT
                         && DIR_O == DIR_RESET)
    else $error("port directions wrong after reset");

  a_group_uniform : assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // (R15)
    (PORTA_OE_N_O[7:0] == 8'h00 || PORTA_OE_N_O[7:0] == 8'hff) &&
    (PORTA_OE_N_O[15:8] == 8'h00 || PORTA_OE_N_O[15:8] == 8'hff) &&
    (PORTB_OE_N_O[7:0] == 8'h00 || PORTB_OE_N_O[7:0] == 8'hff) &&
    (PORTB_OE_N_O[15:8] == 8'h00 || PORTB_OE_N_O[15:8] == 8'hff))
    else $error("direction not uniform within a group");

  a_dir_write : assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // (R15)
    DIR_WE_I |=> DIR_O == $past(DIR_I) && PORTB_OE_N_O[15] == !$past(DIR_I[3])
                 && PORTA_OE_N_O[0] == !$past(DIR_I[0]))
    else $error("direction write not applied");

  a_out_write : assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // (R1)
    OUT_WE_I |=> PORTA_OUT_O == $past(OUT_A_I) && PORTB_OUT_O == $past(OUT_B_I))
    else $error("output data write not applied");

  a_out_hold : assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // (R1)
    !OUT_WE_I |=> $stable(PORTA_OUT_O) && $stable(PORTB_OUT_O))
    else $error("output data changed without write");

  a_sample_capture : assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // (R3)
    SAMPLE_I |=> SAMPLE_VALID_O && DIN_O == $past(lines))
    else $error("sample snapshot wrong");

  a_sample_pulse : assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // (R3)
    !SAMPLE_I |=> !SAMPLE_VALID_O && $stable(DIN_O))
    else $error("snapshot changed without strobe");

  c_plain_count : cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
    CNT_ASSIGN_I[0] && CNT_MODE_I[2:0] == MODE_COUNT
    ##1 CNT_VALUE_O[31:0] != $past(CNT_VALUE_O[31:0]));

  c_quad_count : cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
    CNT_ASSIGN_I[2] && CNT_MODE_I[8:6] == MODE_QUAD
    ##1 CNT_VALUE_O[95:64] != $past(CNT_VALUE_O[95:64]));

  c_ext_reset : cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
    CNT_ASSIGN_I[0] && CNT_RST_EN_I[0] && cnt_r[0] ##1 CNT_VALUE_O[31:0] == CNT_RESET);

  c_port_turn : cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
    DIR_WE_I && DIR_I == 4'h3 ##1 SAMPLE_I ##1 SAMPLE_VALID_O);

endmodule : dio_counter_top

// ---- dio_counter_pkg.sv ----
package dio_counter_pkg;

  // Port and line geometry
  localparam int NUM_LINES  = 32;
  localparam int PORT_W     = 16;
  localparam int GROUP_W    = 8;
  localparam int NUM_GROUPS = 4;
  localparam int SEL_W      = 5;

  // Counter geometry
  localparam int NUM_CNT    = 3;
  localparam int CNT_W      = 32;
  localparam int MODE_W     = 3;

  // Values after reset: groups 0,1 (port A) input, groups 2,3 (port B) output
  localparam logic [NUM_GROUPS-1:0] DIR_RESET  = 4'hc;
  localparam logic [PORT_W-1:0]     OE_N_IN    = 16'hffff;
  localparam logic [PORT_W-1:0]     OE_N_OUT   = 16'h0000;
  localparam logic [PORT_W-1:0]     DOUT_RESET = 16'h0000;
  localparam logic [NUM_LINES-1:0]  DIN_RESET  = 32'h00000000;
  localparam logic [CNT_W-1:0]      CNT_RESET  = 32'h00000000;
  localparam logic [CNT_W-1:0]      CNT_ONE    = 32'h00000001;
  localparam logic [CNT_W-1:0]      CNT_MAX    = 32'hffffffff;

  // Clock and pulse rates, with least clock cycles per input pulse
  localparam int CLK_MHZ        = 250;
  localparam int CNT_MAX_MHZ    = 16;
  localparam int ENC_MAX_MHZ    = 4;
  localparam int CNT_MIN_CYCLES = CLK_MHZ / CNT_MAX_MHZ;
  localparam int ENC_MIN_CYCLES = CLK_MHZ / ENC_MAX_MHZ;

  // Counter operating modes
  typedef enum logic [MODE_W-1:0] {
    MODE_COUNT  = 3'h1,
    MODE_UPDOWN = 3'h2,
    MODE_QUAD   = 3'h4
  } mode_t;

endpackage : dio_counter_pkg

// ---- line_sync.sv ----
`timescale 1ns/10ps
module line_sync
  import dio_counter_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic [NUM_LINES-1:0] lines_i,
  output logic      [NUM_LINES-1:0] lines_o
);

  logic [NUM_LINES-1:0] meta;

  // Two flop synchroniser per line
  generate
    for (genvar i = 0; i < NUM_LINES; i++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta[i]    <= 1'b0;
          lines_o[i] <= 1'b0;
        end else begin
          meta[i]    <= lines_i[i]; // (R17)
          lines_o[i] <= meta[i];
        end
      end
    end
  endgenerate

  // Output equals input delayed by two edges
  a_sync_delay : assert property (@(posedge clk_i) disable iff (rst_i) // (R17)
    !$past(rst_i) && !$past(rst_i, 2) |-> lines_o == $past(lines_i, 2))
    else $error("synchroniser delay is not two cycles");

endmodule : line_sync

// ---- quad_counter.sv ----
`timescale 1ns/10ps
module quad_counter
  import dio_counter_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              assign_i,
  input  wire logic [MODE_W-1:0] mode_i,
  input  wire logic              a_i,
  input  wire logic              b_i,
  input  wire logic              ext_rst_en_i,
  input  wire logic              ext_rst_i,
  output logic      [CNT_W-1:0]  value_o
);

  logic             a_prev;
  logic             b_prev;
  logic             rise_a;
  logic             one_moved;
  logic             clear;
  logic [CNT_W-1:0] next_value;

  // Edge history of the selected lines
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_prev <= 1'b0;
      b_prev <= 1'b0;
    end else begin
      a_prev <= a_i;
      b_prev <= b_i;
    end
  end

  assign rise_a    = a_i & ~a_prev;
  assign one_moved = (a_i ^ a_prev) ^ (b_i ^ b_prev);
  assign clear     = assign_i & ext_rst_en_i & ext_rst_i; // (R11)

  // Step decision for each mode
  always_comb begin
    next_value = value_o;
    unique case (mode_t'(mode_i))
      MODE_COUNT: begin
        if (rise_a) next_value = value_o + CNT_ONE; // (R9) (R10)
      end
      MODE_UPDOWN: begin
        if (rise_a) next_value = b_i ? value_o - CNT_ONE : value_o + CNT_ONE; // (R16)
      end
      MODE_QUAD: begin
        if (one_moved) begin // (R12) (R13)
          next_value = (a_i ^ b_prev) ? value_o + CNT_ONE : value_o - CNT_ONE;
        end
      end
      default: next_value = value_o;
    endcase
  end

  // Count register, external reset first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      value_o <= CNT_RESET;
    end else if (clear) begin
      value_o <= CNT_RESET; // (R11)
    end else if (assign_i) begin
      value_o <= next_value; // (R8) (R6)
    end
  end

  a_ext_reset : assert property (@(posedge clk_i) disable iff (rst_i) // (R11)
    clear |=> value_o == CNT_RESET)
    else $error("external reset did not clear counter");

  a_plain_step : assert property (@(posedge clk_i) disable iff (rst_i) // (R9)
    assign_i && !clear && mode_i == MODE_COUNT && rise_a |=> value_o == $past(value_o) + CNT_ONE)
    else $error("plain counter missed a rising edge");

  a_count_wrap : assert property (@(posedge clk_i) disable iff (rst_i) // (R10)
    assign_i && !clear && mode_i == MODE_COUNT && rise_a && value_o == CNT_MAX
    |=> value_o == CNT_RESET)
    else $error("counter did not wrap to zero");

  a_quad_up : assert property (@(posedge clk_i) disable iff (rst_i) // (R12)
    assign_i && !clear && mode_i == MODE_QUAD && rise_a && !b_i && !b_prev
    |=> value_o == $past(value_o) + CNT_ONE)
    else $error("quadrature forward step wrong");

  a_updown_down : assert property (@(posedge clk_i) disable iff (rst_i) // (R16)
    assign_i && !clear && mode_i == MODE_UPDOWN && rise_a && b_i
    |=> value_o == $past(value_o) - CNT_ONE)
    else $error("up/down counter did not count down");

endmodule : quad_counter

// ---- ext_signal_model.sv ----
`timescale 1ns/10ps
// Outside world on both ports: switches, pulse sources, encoder
module ext_signal_model
  import dio_counter_pkg::*;
(
  input  wire logic [NUM_LINES-1:0] ext_i,
  input  wire logic [PORT_W-1:0]    a_out_i,
  input  wire logic [PORT_W-1:0]    a_oe_n_i,
  input  wire logic [PORT_W-1:0]    b_out_i,
  input  wire logic [PORT_W-1:0]    b_oe_n_i,
  output logic      [PORT_W-1:0]    a_pad_o,
  output logic      [PORT_W-1:0]    b_pad_o
);
  // Outside drives only the lines left as inputs, never against the device
  assign a_pad_o = (a_out_i & ~a_oe_n_i) | (ext_i[PORT_W-1:0] & a_oe_n_i);
  assign b_pad_o = (b_out_i & ~b_oe_n_i) | (ext_i[NUM_LINES-1:PORT_W] & b_oe_n_i);
endmodule : ext_signal_model

// ---- test_digital_io_counter_block.sv ----
`timescale 1ns/10ps
module test_digital_io_counter_block;
  import dio_counter_pkg::*;
  logic        clk, rst, dir_we, out_we, sample;
  logic [3:0]  dir;
  logic [15:0] out_a, out_b, a_pad, b_pad, a_out, a_oe_n, b_out, b_oe_n;
  logic [31:0] ext, din;
  logic [2:0]  assign_en, rst_en;
  logic [8:0]  mode;
  logic [14:0] sel_a, sel_b, sel_rst;
  logic [95:0] cnt;
  logic [3:0]  dir_seen;
  logic        valid;
  int          miscompares = 0;
  int          checks_done = 0;

  dio_counter_top i_dut (.CLK_I(clk), .SYS_RST_I(rst), .PORTA_IN_I(a_pad), .PORTA_OUT_O(a_out),
    .PORTA_OE_N_O(a_oe_n), .PORTB_IN_I(b_pad), .PORTB_OUT_O(b_out), .PORTB_OE_N_O(b_oe_n),
    .DIR_WE_I(dir_we), .DIR_I(dir), .DIR_O(dir_seen), .OUT_WE_I(out_we), .OUT_A_I(out_a),
    .OUT_B_I(out_b), .SAMPLE_I(sample), .DIN_O(din), .SAMPLE_VALID_O(valid),
    .CNT_ASSIGN_I(assign_en), .CNT_MODE_I(mode), .CNT_SEL_A_I(sel_a), .CNT_SEL_B_I(sel_b),
    .CNT_SEL_RST_I(sel_rst), .CNT_RST_EN_I(rst_en), .CNT_VALUE_O(cnt));

  ext_signal_model i_ext (.ext_i(ext), .a_out_i(a_out), .a_oe_n_i(a_oe_n), .b_out_i(b_out),
    .b_oe_n_i(b_oe_n), .a_pad_o(a_pad), .b_pad_o(b_pad));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Clean pulses, 16 cycles a period, no bounce
  task automatic pulse(input int line, input int n);
    repeat (n) begin
      @(posedge clk) ext[line] <= 1'b1;
      tick(7);
      @(posedge clk) ext[line] <= 1'b0;
      tick(7);
    end
    tick(4);
  endtask : pulse

  // One quadrature step on lines 5 (A) and 6 (B)
  task automatic qstep(input logic a, input logic b);
    @(posedge clk) ext[5] <= a;
    ext[6] <= b;
    tick(15);
  endtask : qstep

  task automatic end_of_test;
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // Watchdog, tests need about 720 cycles
  initial begin
    #40000;
    miscompares++;
    end_of_test;
  end

  initial begin
    rst = 1'b1; dir_we = 1'b0; out_we = 1'b0; sample = 1'b0; dir = 4'h0;
    out_a = 16'h0000; out_b = 16'h0000; ext = 32'h00000000; assign_en = 3'h0;
    rst_en = 3'h0; mode = {3'h4, 3'h2, 3'h1};
    sel_a = {5'h05, 5'h14, 5'h03}; sel_b = {5'h06, 5'h15, 5'h00}; sel_rst = {10'h000, 5'h07};
    tick(20);
    @(posedge clk) rst <= 1'b0;
    tick(1);
    check(dir_seen, 4'hc);
    check({b_oe_n, a_oe_n}, 32'h0000ffff);
    check(cnt[31:0], 32'h00000000);
    // Mixed directions per group, output data, snapshot
    @(posedge clk) dir_we <= 1'b1;
    dir <= 4'h5; out_we <= 1'b1; out_a <= 16'ha5a5; out_b <= 16'h3c3c; ext <= 32'h5a00c300;
    @(posedge clk) dir_we <= 1'b0;
    out_we <= 1'b0;
    #1;
    check(dir_seen, 4'h5);
    check({b_oe_n, a_oe_n}, 32'hff00ff00);
    check({b_out, a_out}, 32'h3c3ca5a5);
    tick(4);
    @(posedge clk) sample <= 1'b1;
    @(posedge clk) sample <= 1'b0;
    #1;
    check(valid, 1'b1);
    check(din, 32'h5a3cc3a5);
    tick(1);
    check(valid, 1'b0);
    // Port A driving, port B reading, strobe right behind the turn
    @(posedge clk) dir_we <= 1'b1;
    dir <= 4'h3;
    @(posedge clk) dir_we <= 1'b0;
    sample <= 1'b1;
    @(posedge clk) sample <= 1'b0;
    #1;
    check({b_oe_n, a_oe_n}, 32'hffff0000);
    check(valid, 1'b1);
    tick(3);
    @(posedge clk) sample <= 1'b1;
    @(posedge clk) sample <= 1'b0;
    #1;
    check(din, 32'h5a00a5a5);
    // All inputs, then counting only once lines are assigned
    @(posedge clk) dir_we <= 1'b1;
    dir <= 4'h0; ext <= 32'h00000000;
    @(posedge clk) dir_we <= 1'b0;
    tick(4);
    check({b_oe_n, a_oe_n}, 32'hffffffff);
    pulse(3, 4);
    check(cnt[31:0], 32'h00000000);
    @(posedge clk) assign_en <= 3'h7;
    pulse(3, 5);
    check(cnt[31:0], 32'h00000005);
    // Up/down: B high counts down, two's complement
    @(posedge clk) ext[21] <= 1'b1;
    pulse(20, 3);
    check(cnt[63:32], 32'hfffffffd);
    @(posedge clk) ext[21] <= 1'b0;
    pulse(20, 1);
    check(cnt[63:32], 32'hfffffffe);
    // Plain mode from near the top wraps to zero
    @(posedge clk) mode <= {3'h4, 3'h1, 3'h1};
    pulse(20, 1);
    check(cnt[63:32], 32'hffffffff);
    pulse(20, 1);
    check(cnt[63:32], 32'h00000000);
    // Undefined mode code holds the count
    @(posedge clk) mode <= {3'h4, 3'h0, 3'h1};
    pulse(20, 1);
    check(cnt[63:32], 32'h00000000);
    // Quadrature: eight steps forward, twelve back
    repeat (2) begin
      qstep(1'b1, 1'b0); qstep(1'b1, 1'b1); qstep(1'b0, 1'b1); qstep(1'b0, 1'b0);
    end
    check(cnt[95:64], 32'h00000008);
    repeat (3) begin
      qstep(1'b0, 1'b1); qstep(1'b1, 1'b1); qstep(1'b1, 1'b0); qstep(1'b0, 1'b0);
    end
    check(cnt[95:64], 32'hfffffffc);
    check(cnt[31:0], 32'h00000005);
    // External reset on line 7 clears and holds counter 0
    @(posedge clk) rst_en <= 3'h1;
    tick(4);
    check(cnt[31:0], 32'h00000005);
    @(posedge clk) ext[7] <= 1'b1;
    pulse(3, 2);
    check(cnt[31:0], 32'h00000000);
    @(posedge clk) ext[7] <= 1'b0;
    pulse(3, 1);
    check(cnt[31:0], 32'h00000001);
    end_of_test;
  end
endmodule : test_digital_io_counter_block
